/* File: verilog/pxm_pkg.sv */
// Behaviour
// - MII moves one nibble per clock each way
// - MAC transmit enable/error code idle, data, error
// - MII receive codes idle, false carrier, data, errors
// - RMII moves one dibble per reference clock
// - RMII slave follows MAC reference rising edges
// - RMII master drives clock out on data bit 3
// - RMII MAC enable low idle, high data
// - RMII receive codes idle, data, errors
// - RMII also drives separate data valid, error
// - RMII receive data buffered in programmable FIFO
// - RGMII control on both edges, data rising
// - RGMII clocks run at link rate
// - MII transmit inputs always actively driven
// - RGMII MAC control pair idle, data, error
// - RGMII receive control pair with false carrier
// - RGMII idle lines carry duplex, speed, link
package pxm_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 100;  // Own clock period
	localparam int LCLK_PERIOD_NS = 800;  // Link clock period
	// Half link period in own cycles, rounded down, never below one
	localparam int LCLK_HALF_INT  = (LCLK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
	                                (LCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [7:0] LCLK_HALF = 8'(LCLK_HALF_INT);

	// ****************************************
	// Sizes and reset values
	// ****************************************
	localparam int         FIFO_DEPTH = 16;     // Receive FIFO words
	localparam int         FIFO_W     = 6;      // {last, err, nibble}
	localparam logic [7:0] DIV_RST    = 8'h00;  // Divider after reset
	localparam logic [3:0] NIB_IDLE   = 4'h0;   // Idle nibble
	localparam logic [3:0] NIB_FCAR   = 4'he;   // False carrier nibble

	// ****************************************
	// Forms and encodings
	// ****************************************
	localparam logic [1:0] MODE_MII      = 2'h0;
	localparam logic [1:0] MODE_RMII_SLV = 2'h1;  // MAC makes reference
	localparam logic [1:0] MODE_RMII_MST = 2'h2;  // Device makes reference
	localparam logic [1:0] MODE_RGMII    = 2'h3;
	localparam logic [1:0] SPEED_2M5     = 2'h0;
	localparam logic [1:0] SPEED_25M     = 2'h1;
	localparam logic [1:0] SPEED_125M    = 2'h2;

	// Receive drain states
	typedef enum logic [2:0] {
		PXM_RX_IDLE = 3'b001,
		PXM_RX_DATA = 3'b010,
		PXM_RX_FCAR = 3'b100
	} pxm_rx_st_t;

	// True for either reduced form
	function automatic logic pxm_is_rmii(input logic [1:0] m);
		return (m == MODE_RMII_SLV) || (m == MODE_RMII_MST);
	endfunction

	// Place a nibble or its low dibble on the data lines
	function automatic logic [3:0] pxm_first(input logic [1:0] m, input logic [3:0] n);
		return pxm_is_rmii(m) ? {2'b00, n[1:0]} : n;
	endfunction

endpackage

/* File: verilog/pxm_xmii_if.sv */
`timescale 1ns/1ps
// ****************************************
// MAC side pins between device and MAC
// ****************************************
interface pxm_xmii_if;
	logic       lclk_phy;         // Device made clock (MII, RGMII)
	logic       ref_clock_input;  // MAC made reference (RMII slave)
	logic [3:0] tx_d;             // Transmit data
	logic       tx_en;            // Enable, or RGMII control
	logic       tx_er;            // MII transmit error
	logic [3:0] rx_d;             // Receive data, bit 3 clock in RMII master
	logic       rx_dv;            // Data valid, carrier/valid, or RGMII control
	logic       rx_er;            // Receive error
	logic       rx_dvs;           // Separate RMII data valid

	modport phy (
		input  ref_clock_input, tx_d, tx_en, tx_er,
		output lclk_phy, rx_d, rx_dv, rx_er, rx_dvs
	);
	modport mac (
		input  lclk_phy, rx_d, rx_dv, rx_er, rx_dvs,
		output ref_clock_input, tx_d, tx_en, tx_er
	);
endinterface

/* File: verilog/pxm_fifo.sv */
`timescale 1ns/1ps
module pxm_fifo #(
	parameter int W     = 6,
	parameter int DEPTH = 16
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [W-1:0]             in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [W-1:0]                  out_data,
	output logic [$clog2(DEPTH):0]        level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [W-1:0] mem [DEPTH];  // Storage
	logic [AW:0]  wr_r;         // Write pointer with wrap bit
	logic [AW:0]  rd_r;         // Read pointer with wrap bit
	logic         push;
	logic         pop;

	assign level     = wr_r - rd_r;
	assign in_ready  = (level != FULL);
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_r[AW-1:0]];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	// Pointers; frozen while the enable is low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end

	// Storage needs no reset, it is only read behind the pointers
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end
endmodule

/* File: verilog/pxm_phy_end.sv */
`timescale 1ns/1ps
module pxm_phy_end #(
	parameter int FIFO_DEPTH_P = pxm_pkg::FIFO_DEPTH
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	input  wire logic [1:0]                    mode,
	input  wire logic                          link_up,
	input  wire logic                          full_duplex,
	input  wire logic [$clog2(FIFO_DEPTH_P):0] rx_fifo_start,
	input  wire logic                          rx_valid,
	output logic                               rx_ready,
	input  wire logic [3:0]                    rx_data,
	input  wire logic                          rx_err,
	input  wire logic                          rx_last,
	input  wire logic                          rx_fcar,
	output logic                               txo_valid,
	output logic [3:0]                         txo_data,
	output logic                               txo_err,
	pxm_xmii_if.phy                            xm
);
	import pxm_pkg::*;

	// ****************************************
	// Link clock
	// ****************************************
	logic       own_gen;   // Device makes the link clock
	logic       rmii;      // Either reduced form
	logic [7:0] div_r;     // Half period divider
	logic       lclk_r;    // Link clock made here
	logic       div_hit;   // Divider wraps this cycle
	logic [1:0] orise_r;   // Own rising edge, delayed to match sync
	logic [1:0] ofall_r;   // Own falling edge, delayed to match sync
	logic [2:0] fsync_r;   // Reference from MAC, two stages then edge
	logic       rise_s;    // Rising edge as seen with synced pins
	logic       fall_s;    // Falling edge as seen with synced pins
	logic       rg_ph_r;   // RGMII second half of link cycle

	assign rmii    = pxm_is_rmii(mode);
	assign own_gen = (mode != MODE_RMII_SLV);
	assign div_hit = (div_r == LCLK_HALF - 8'h01);

	// Divider, own edges delayed to match pin syncs, and RGMII control phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_r   <= DIV_RST;
			lclk_r  <= 1'b0;
			orise_r <= 2'b00;
			ofall_r <= 2'b00;
			rg_ph_r <= 1'b0;
		end else if (ce) begin
			orise_r <= {orise_r[0], own_gen & div_hit & ~lclk_r};
			ofall_r <= {ofall_r[0], own_gen & div_hit & lclk_r};
			if (rise_s) begin
				rg_ph_r <= 1'b1;
			end else if (fall_s) begin
				rg_ph_r <= 1'b0;
			end
			if (!own_gen) begin
				div_r  <= DIV_RST;
				lclk_r <= 1'b0;
			end else if (div_hit) begin
				div_r  <= DIV_RST;
				lclk_r <= ~lclk_r;
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	assign rise_s = own_gen ? orise_r[1] : (fsync_r[1] & ~fsync_r[2]);
	assign fall_s = own_gen ? ofall_r[1] : (~fsync_r[1] & fsync_r[2]);

	// ****************************************
	// Transmit capture
	// ****************************************
	logic [5:0] txs1_r;    // Pin stage one {er, en, d}
	logic [5:0] txs2_r;    // Pin stage two
	logic       t_en;
	logic       t_er;
	logic [3:0] t_d;
	logic       half_r;    // Low dibble held
	logic [1:0] low_r;     // Held low dibble
	logic       rg_ctl_r;  // Control value from rising edge
	logic [3:0] rg_d_r;    // Nibble from rising edge

	assign t_er = txs2_r[5];
	assign t_en = txs2_r[4];
	assign t_d  = txs2_r[3:0];

	// Pins from the MAC pass two stages; first reference stage feeds the second only
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txs1_r  <= 6'h00;
			txs2_r  <= 6'h00;
			fsync_r <= 3'b000;
		end else if (ce) begin
			txs1_r  <= {xm.tx_er, xm.tx_en, xm.tx_d};
			txs2_r  <= txs1_r;
			fsync_r <= {fsync_r[1:0], xm.ref_clock_input};
		end
	end

	// Decode the transmit stream into nibbles for the line side
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txo_valid <= 1'b0;
			txo_data  <= NIB_IDLE;
			txo_err   <= 1'b0;
			half_r    <= 1'b0;
			low_r     <= 2'b00;
			rg_ctl_r  <= 1'b0;
			rg_d_r    <= NIB_IDLE;
		end else if (ce) begin
			txo_valid <= 1'b0;
			if (rise_s) begin
				case (mode)
					MODE_MII: begin
						// Enable low is idle; error alone is ignored
						if (t_en) begin
							txo_valid <= 1'b1;
							txo_data  <= t_d;
							txo_err   <= t_er;
						end
					end
					MODE_RGMII: begin
						// Data and first control value on the rising edge
						rg_ctl_r <= t_en;
						rg_d_r   <= t_d;
					end
					default: begin
						// Two dibbles, low first, while enable is high
						if (!t_en) begin
							half_r <= 1'b0;
						end else if (half_r) begin
							txo_valid <= 1'b1;
							txo_data  <= {t_d[1:0], low_r};
							txo_err   <= 1'b0;
							half_r    <= 1'b0;
						end else begin
							low_r  <= t_d[1:0];
							half_r <= 1'b1;
						end
					end
				endcase
			end else if (fall_s && mode == MODE_RGMII && rg_ctl_r) begin
				// Second control value marks error propagation
				txo_valid <= 1'b1;
				txo_data  <= rg_d_r;
				txo_err   <= t_en;
			end
		end
	end

	// ****************************************
	// Receive FIFO and drain
	// ****************************************
	logic [FIFO_W-1:0]               f_data;
	logic                            f_valid;
	logic                            pop;
	logic [$clog2(FIFO_DEPTH_P):0]   f_level;
	pxm_rx_st_t                      st_r;        // Drain state
	logic                            sub_r;       // High dibble still due
	logic [3:0]                      cur_r;       // Nibble on the lines
	logic [3:0]                      rxd_r;       // Receive data lines
	logic                            dv_r;        // Data valid
	logic                            er_r;        // Receive error
	logic                            fcar_pend_r; // False carrier waiting
	logic                            fcar_take;
	logic [3:0]                      idle_nib;

	// Buffers line data against the link clock; depth of fill sets the start
	pxm_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH_P)
	) pxm_fifo_inst (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   ({rx_last, rx_err, rx_data}),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data),
		.level     (f_level)
	);

	// Idle lines carry in-band status in RGMII
	assign idle_nib = (mode == MODE_RGMII) ? {full_duplex, SPEED_25M, link_up}
	                                       : NIB_IDLE;
	assign fcar_take = fall_s && !sub_r && st_r == PXM_RX_IDLE && fcar_pend_r && !rmii;

	// Pop one nibble per link cycle, two link cycles per nibble in RMII
	always_comb begin
		pop = 1'b0;
		if (fall_s && !(rmii && sub_r)) begin
			if (st_r == PXM_RX_DATA) begin
				pop = f_valid;
			end else if (st_r == PXM_RX_IDLE && !(fcar_pend_r && !rmii)) begin
				pop = f_valid && (f_level >= rx_fifo_start);
			end
		end
	end

	// A new request wins over the clear of an old one
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fcar_pend_r <= 1'b0;
		end else if (ce) begin
			fcar_pend_r <= (rx_fcar && !rmii) || (fcar_pend_r && !fcar_take && !rmii);
		end
	end

	// Drain machine; new values launch on falling edges for the next rise
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r  <= PXM_RX_IDLE;
			sub_r <= 1'b0;
			cur_r <= NIB_IDLE;
			rxd_r <= NIB_IDLE;
			dv_r  <= 1'b0;
			er_r  <= 1'b0;
		end else if (ce && fall_s) begin
			if (rmii && sub_r) begin
				rxd_r <= {2'b00, cur_r[3:2]};
				sub_r <= 1'b0;
			end else if (pop) begin
				cur_r <= f_data[3:0];
				rxd_r <= pxm_first(mode, f_data[3:0]);
				dv_r  <= 1'b1;
				er_r  <= f_data[4];
				sub_r <= rmii;
				st_r  <= f_data[5] ? PXM_RX_IDLE : PXM_RX_DATA;
			end else begin
				case (st_r)
					PXM_RX_IDLE: begin
						if (fcar_pend_r && !rmii) begin
							rxd_r <= NIB_FCAR;
							dv_r  <= 1'b0;
							er_r  <= 1'b1;
							st_r  <= PXM_RX_FCAR;
						end else begin
							rxd_r <= idle_nib;
							dv_r  <= 1'b0;
							er_r  <= 1'b0;
						end
					end
					default: begin
						// Underrun or end of false carrier returns to idle
						rxd_r <= idle_nib;
						dv_r  <= 1'b0;
						er_r  <= 1'b0;
						st_r  <= PXM_RX_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Pins; unused ones held low
	// ****************************************
	assign xm.lclk_phy = (mode == MODE_MII || mode == MODE_RGMII) ? lclk_r : 1'b0;
	assign xm.rx_d     = (mode == MODE_RMII_MST) ? {lclk_r, rxd_r[2:0]} : rxd_r;
	assign xm.rx_dv    = (mode == MODE_RGMII) ? (rg_ph_r ? er_r : dv_r) : dv_r;
	assign xm.rx_er    = (mode == MODE_RGMII) ? 1'b0 : er_r;
	assign xm.rx_dvs   = rmii ? dv_r : 1'b0;
endmodule

/* File: verilog/pxm_mac_end.sv */
`timescale 1ns/1ps
module pxm_mac_end (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [1:0] mode,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [3:0] tx_data,
	input  wire logic       tx_err,
	output logic            rxo_valid,
	output logic [3:0]      rxo_data,
	output logic            rxo_err,
	output logic            rxo_fcar,
	output logic            st_link_r,
	output logic            st_duplex_r,
	output logic [1:0]      st_speed_r,
	pxm_xmii_if.mac         xm
);
	import pxm_pkg::*;

	// ****************************************
	// Link clock
	// ****************************************
	logic       own_gen;   // MAC makes the reference
	logic       rmii;
	logic [7:0] div_r;
	logic       lclk_r;
	logic       div_hit;
	logic [1:0] orise_r;
	logic [1:0] ofall_r;
	logic [2:0] fsync_r;   // Device clock, two stages then edge
	logic       rise_s;
	logic       fall_s;

	assign rmii    = pxm_is_rmii(mode);
	assign own_gen = (mode == MODE_RMII_SLV);
	assign div_hit = (div_r == LCLK_HALF - 8'h01);

	// Reference divider, only in RMII slave
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_r  <= DIV_RST;
			lclk_r <= 1'b0;
		end else if (ce) begin
			if (!own_gen) begin
				div_r  <= DIV_RST;
				lclk_r <= 1'b0;
			end else if (div_hit) begin
				div_r  <= DIV_RST;
				lclk_r <= ~lclk_r;
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	// Own edges delayed to line up with synced pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			orise_r <= 2'b00;
			ofall_r <= 2'b00;
		end else if (ce) begin
			orise_r <= {orise_r[0], own_gen & div_hit & ~lclk_r};
			ofall_r <= {ofall_r[0], own_gen & div_hit & lclk_r};
		end
	end

	// RMII master clock arrives on data bit 3
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fsync_r <= 3'b000;
		end else if (ce) begin
			fsync_r <= {fsync_r[1:0], (mode == MODE_RMII_MST) ? xm.rx_d[3] : xm.lclk_phy};
		end
	end

	assign rise_s = own_gen ? orise_r[1] : (fsync_r[1] & ~fsync_r[2]);
	assign fall_s = own_gen ? ofall_r[1] : (~fsync_r[1] & fsync_r[2]);

	// ****************************************
	// Receive decode
	// ****************************************
	logic [7:0] rxs1_r;    // Pin stage one {dvs, er, dv, d}
	logic [7:0] rxs2_r;    // Pin stage two
	logic       r_dvs;
	logic       r_er;
	logic       r_dv;
	logic [3:0] r_d;
	logic       half_r;
	logic [1:0] low_r;
	logic       low_er_r;
	logic       rg_ctl_r;
	logic [3:0] rg_d_r;

	assign r_dvs = rxs2_r[6];
	assign r_er  = rxs2_r[5];
	assign r_dv  = rxs2_r[4];
	assign r_d   = rxs2_r[3:0];

	// Device pins pass two stages
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxs1_r <= 8'h00;
			rxs2_r <= 8'h00;
		end else if (ce) begin
			rxs1_r <= {1'b0, xm.rx_dvs, xm.rx_er, xm.rx_dv, xm.rx_d};
			rxs2_r <= rxs1_r;
		end
	end

	// Nibbles, false carrier and in-band status out of the receive stream
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxo_valid   <= 1'b0;
			rxo_data    <= NIB_IDLE;
			rxo_err     <= 1'b0;
			rxo_fcar    <= 1'b0;
			half_r      <= 1'b0;
			low_r       <= 2'b00;
			low_er_r    <= 1'b0;
			rg_ctl_r    <= 1'b0;
			rg_d_r      <= NIB_IDLE;
			st_link_r   <= 1'b0;
			st_duplex_r <= 1'b0;
			st_speed_r  <= SPEED_2M5;
		end else if (ce) begin
			rxo_valid <= 1'b0;
			rxo_fcar  <= 1'b0;
			if (rise_s) begin
				case (mode)
					MODE_MII: begin
						if (r_dv) begin
							rxo_valid <= 1'b1;
							rxo_data  <= r_d;
							rxo_err   <= r_er;
						end else if (r_er && r_d == NIB_FCAR) begin
							rxo_fcar <= 1'b1;
						end
					end
					MODE_RGMII: begin
						rg_ctl_r <= r_dv;
						rg_d_r   <= r_d;
					end
					default: begin
						// Separate valid frees us from splitting carrier and valid
						if (!(r_dv && r_dvs)) begin
							half_r <= 1'b0;
						end else if (half_r) begin
							rxo_valid <= 1'b1;
							rxo_data  <= {r_d[1:0], low_r};
							rxo_err   <= r_er | low_er_r;
							half_r    <= 1'b0;
						end else begin
							low_r    <= r_d[1:0];
							low_er_r <= r_er;
							half_r   <= 1'b1;
						end
					end
				endcase
			end else if (fall_s && mode == MODE_RGMII) begin
				case ({rg_ctl_r, r_dv})
					2'b10, 2'b11: begin
						rxo_valid <= 1'b1;
						rxo_data  <= rg_d_r;
						rxo_err   <= r_dv;
					end
					2'b01: begin
						rxo_fcar <= (rg_d_r == NIB_FCAR);
					end
					default: begin
						st_duplex_r <= rg_d_r[3];
						st_speed_r  <= rg_d_r[2:1];
						st_link_r   <= rg_d_r[0];
					end
				endcase
			end
		end
	end

	// ****************************************
	// Transmit launch
	// ****************************************
	logic       sub_r;     // High dibble still due
	logic [3:0] cur_r;
	logic [3:0] td_r;
	logic       en_r;
	logic       er_r;
	logic       rg_ph_r;

	// A word is taken on each launch slot; no word means idle
	assign tx_ready = fall_s && !(rmii && sub_r);

	// Lines are always driven, idle between frames
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sub_r <= 1'b0;
			cur_r <= NIB_IDLE;
			td_r  <= NIB_IDLE;
			en_r  <= 1'b0;
			er_r  <= 1'b0;
		end else if (ce && fall_s) begin
			if (rmii && sub_r) begin
				td_r  <= {2'b00, cur_r[3:2]};
				sub_r <= 1'b0;
			end else if (tx_valid) begin
				cur_r <= tx_data;
				td_r  <= pxm_first(mode, tx_data);
				en_r  <= 1'b1;
				er_r  <= rmii ? 1'b0 : tx_err;
				sub_r <= rmii;
			end else begin
				td_r <= NIB_IDLE;
				en_r <= 1'b0;
				er_r <= 1'b0;
			end
		end
	end

	// Control phase for the second edge value
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rg_ph_r <= 1'b0;
		end else if (ce) begin
			if (rise_s) begin
				rg_ph_r <= 1'b1;
			end else if (fall_s) begin
				rg_ph_r <= 1'b0;
			end
		end
	end

	assign xm.ref_clock_input = own_gen ? lclk_r : 1'b0;
	assign xm.tx_d  = td_r;
	assign xm.tx_en = (mode == MODE_RGMII) ? (rg_ph_r ? er_r : en_r) : en_r;
	assign xm.tx_er = (mode == MODE_MII) ? er_r : 1'b0;
endmodule

/* File: tb/pxm_xmii_checker.sv */
`timescale 1ns/1ps
module pxm_xmii_checker (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic [1:0] mode,
	input wire logic       lclk_phy,
	input wire logic       ref_clock_input,
	input wire logic       tx_en,
	input wire logic       tx_er,
	input wire logic [3:0] rx_d,
	input wire logic       rx_dv,
	input wire logic       rx_er,
	input wire logic       rx_dvs
);
	import pxm_pkg::*;
	// ****************************************
	// Pin checks in the own clock domain
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Device clock: four cycles high, then low
	chk_lclk_period: assert property ($rose(lclk_phy) |-> lclk_phy[*4] ##1 !lclk_phy)
		else $error("device link clock half period wrong");
	// Master reference on data bit 3 keeps the same rate
	chk_mst_clk_out: assert property (mode == MODE_RMII_MST && $rose(rx_d[3])
		|-> rx_d[3][*4] ##1 !rx_d[3]) else $error("reference out on bit 3 wrong");
	chk_lclk_quiet: assert property (pxm_is_rmii(mode) |-> !lclk_phy)
		else $error("device clock runs in reduced form");
	chk_ref_quiet: assert property (mode != MODE_RMII_SLV |-> !ref_clock_input)
		else $error("MAC reference runs outside slave form");
	chk_dvs_quiet: assert property (!pxm_is_rmii(mode) |-> !rx_dvs)
		else $error("separate valid outside reduced form");
	chk_rgmii_no_er: assert property (mode == MODE_RGMII |-> !rx_er)
		else $error("receive error pin used in RGMII");
	chk_tx_er_quiet: assert property (mode != MODE_MII |-> !tx_er)
		else $error("transmit error pin used outside MII");
	// Enable low with error high never leaves the MAC
	chk_mii_tx_code: assert property (mode == MODE_MII |-> !(tx_er && !tx_en))
		else $error("reserved transmit code sent");
	chk_mii_fcar: assert property (mode == MODE_MII && !rx_dv && rx_er |-> rx_d == NIB_FCAR)
		else $error("reserved receive code sent");
	chk_rmii_idle: assert property (pxm_is_rmii(mode) && !rx_dv |-> !rx_er)
		else $error("reduced form error while idle");
	// Main scenarios reached
	cov_dvs: cover property (rx_dvs);
	cov_fcar: cover property (mode == MODE_MII && rx_er && !rx_dv);
	cov_rgmii: cover property (mode == MODE_RGMII && rx_dv);
endmodule

/* File: tb/tb_phy_xmii_mac_side_port.sv */
`timescale 1ns/1ps
module tb_phy_xmii_mac_side_port;
	import pxm_pkg::*;
	logic       ref_clk = 0, rst = 1, ce = 1, link_up = 1, full_duplex = 1;
	logic [1:0] mode = MODE_MII;
	logic [4:0] fstart = 5'h10;             // Drain waits for a full FIFO
	logic       rx_valid = 0, rx_err = 0, rx_last = 0, rx_fcar = 0;
	logic       tx_valid = 0, tx_err = 0;
	logic [3:0] rx_data = 4'h0, tx_data = 4'h0;
	logic       rx_ready, txo_valid, txo_err, tx_ready, rxo_valid, rxo_err, rxo_fcar;
	logic [3:0] txo_data, rxo_data;
	logic       st_link, st_duplex;
	logic [1:0] st_speed;
	int         num_errors = 0, checked = 0, nf = 0;
	logic [4:0] txq[$], rxq[$];             // Collected {err, nibble}
	// ****************************************
	// Both ends face each other
	// ****************************************
	always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	pxm_xmii_if pxm_xmii_if_inst ();
	pxm_phy_end pxm_phy_end_inst (.ref_clk, .rst, .ce, .mode, .link_up, .full_duplex,
		.rx_fifo_start(fstart), .rx_valid, .rx_ready, .rx_data, .rx_err, .rx_last, .rx_fcar,
		.txo_valid, .txo_data, .txo_err, .xm(pxm_xmii_if_inst.phy));
	pxm_mac_end pxm_mac_end_inst (.ref_clk, .rst, .ce, .mode, .tx_valid, .tx_ready, .tx_data,
		.tx_err, .rxo_valid, .rxo_data, .rxo_err, .rxo_fcar, .st_link_r(st_link),
		.st_duplex_r(st_duplex), .st_speed_r(st_speed), .xm(pxm_xmii_if_inst.mac));
	pxm_xmii_checker pxm_xmii_checker_inst (.ref_clk, .rst, .mode,
		.lclk_phy(pxm_xmii_if_inst.lclk_phy), .ref_clock_input(pxm_xmii_if_inst.ref_clock_input),
		.tx_en(pxm_xmii_if_inst.tx_en), .tx_er(pxm_xmii_if_inst.tx_er),
		.rx_d(pxm_xmii_if_inst.rx_d), .rx_dv(pxm_xmii_if_inst.rx_dv),
		.rx_er(pxm_xmii_if_inst.rx_er), .rx_dvs(pxm_xmii_if_inst.rx_dvs));
	// Collect what each user side hands out
	always @(posedge ref_clk) begin
		if (txo_valid) txq.push_back({txo_err, txo_data});
		if (rxo_valid) rxq.push_back({rxo_err, rxo_data});
		if (rxo_fcar) nf++;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A wait ran out: count it and stop
	task automatic hang(input string what);
		num_errors++;
		$display("[ERR] %s exp done got timeout", what);
		final_report();
	endtask
	// Mode only changes under reset
	task automatic start(input logic [1:0] m);
		rst = 1;
		mode = m;
		txq.delete();
		rxq.delete();
		nf = 0;
		repeat (6) step();
		rst = 0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Streamed frame, error on third nibble; gap must give nothing
	task automatic tx_frame();
		int k;
		for (int i = 0; i < 4; i++) begin
			tx_valid = 1;
			tx_data = 4'(4'ha + i);
			tx_err = (i == 2);
			for (k = 0; k < 40 && tx_ready !== 1'b1; k++) step();
			if (k == 40) hang("tx_ready");
			step();
		end
		tx_valid = 0;
		tx_err = 0;
		for (k = 0; k < 120 && txq.size() < 4; k++) step();
		if (k == 120) hang("tx collect");
		repeat (40) step();
		chk("tx count", 8'h04, 8'(txq.size()));
		for (int i = 0; i < 4; i++)
			chk("tx nibble", {3'h0, i == 2 && (mode == MODE_MII || mode == MODE_RGMII),
				4'(4'ha + i)}, {3'h0, txq[i]});
	endtask
	// Fill FIFO to refusal, then drain whole frame
	task automatic rx_frame();
		int k;
		rx_valid = 1;
		for (int i = 0; i < 16; i++) begin
			rx_data = 4'(i);
			rx_err = (i == 5);
			rx_last = (i == 15);
			step();
		end
		chk("rx_ready full", 8'h00, {7'h0, rx_ready});
		rx_valid = 0;
		rx_last = 0;
		for (k = 0; k < 700 && rxq.size() < 16; k++) step();
		if (k == 700) hang("rx drain");
		for (int i = 0; i < 16; i++)
			chk("rx nibble", {3'h0, i == 5, 4'(i)}, {3'h0, rxq[i]});
	endtask
	// False carrier only outside reduced forms
	task automatic fcar();
		int k;
		rx_fcar = 1;
		step();
		rx_fcar = 0;
		for (k = 0; k < 60 && nf == 0; k++) step();
		if (k == 60 && mode != MODE_RMII_SLV && mode != MODE_RMII_MST) hang("fcar");
		chk("fcar", (mode == MODE_RMII_SLV || mode == MODE_RMII_MST) ? 8'h00 : 8'h01,
			8'(nf));
	endtask
	// In-band status follows link and duplex inputs on idle cycles
	task automatic status();
		for (int j = 0; j < 2; j++) begin
			chk("status", {4'h0, full_duplex, SPEED_25M, link_up}, {4'h0, st_duplex, st_speed,
				st_link});
			link_up = 0;
			full_duplex = 0;
			repeat (40) step();
		end
		link_up = 1;
		full_duplex = 1;
	endtask
	// ****************************************
	// Main sequence over every form
	// ****************************************
	initial begin
		for (int m = 0; m < 4; m++) begin
			start(2'(m));
			tx_frame();
			rx_frame();
			fcar();
			if (mode == MODE_RGMII)
				status();
		end
		final_report();
	end
endmodule
